// *** rtl/gap_counter.sv ***
// Single counter giving the gapped nibble clock, frame marker and sample strobe
`timescale 1ns/1ps
`include "nib_consts.svh"
module gap_counter #(
  parameter int NIBBLES = `NIBBLES_PER_FRAME,
  parameter int GAPS = `LONG_GAPS_PER_FRAME,
  parameter int NORMAL_GAP = `NORMAL_GAP_TICKS,
  parameter int LONG_GAP = `LONG_GAP_TICKS
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic run, // Counter enabled
  input wire logic tick, // One reference clock rising edge
  input wire logic realign, // Renumber current nibble as first of frame
  output logic nib_clk, // Gapped nibble clock level
  output logic marker, // High during the last nibble of a frame
  output logic sample // Pulse at the third reference edge after a clock rise
);
  localparam int PER_BLK = NIBBLES / GAPS;
  localparam int NW = $clog2(PER_BLK);
  localparam int BW = $clog2(GAPS);

  if (NIBBLES % GAPS != 0 || NORMAL_GAP < `SAMPLE_EDGE + 1 || LONG_GAP <= NORMAL_GAP
      || LONG_GAP > 7 || PER_BLK < 2) begin : g_check
    $error("gap_counter: unsupported frame geometry");
  end

  logic [2:0] phase;
  logic [NW-1:0] nib;
  logic [BW-1:0] blk;
  logic [2:0] next_phase;
  logic [NW-1:0] next_nib;
  logic [BW-1:0] next_blk;
  logic [2:0] len;
  logic wrap;

  // One long slot opens each block, where the framer drops in an overhead bit
  assign len = (nib == '0) ? 3'(LONG_GAP - 1) : 3'(NORMAL_GAP - 1);
  assign wrap = tick && (phase == len);

  always_comb begin
    next_phase = phase;
    next_nib = nib;
    next_blk = blk;
    if (tick) begin
      if (wrap) begin
        next_phase = 3'h0;
        if (nib == NW'(PER_BLK - 1)) begin
          next_nib = '0;
          next_blk = (blk == BW'(GAPS - 1)) ? '0 : blk + BW'(1);
        end else begin
          next_nib = nib + NW'(1);
        end
      end else begin
        next_phase = phase + 3'h1;
      end
    end
    if (realign) begin
      next_nib = '0;
      next_blk = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    // Idle parks on the last slot so the first tick after a start opens a whole pulse
    if (!presetn) begin
      phase <= 3'(NORMAL_GAP - 1);
      nib <= NW'(PER_BLK - 1);
      blk <= BW'(GAPS - 1);
    end else if (!run) begin
      phase <= 3'(NORMAL_GAP - 1);
      nib <= NW'(PER_BLK - 1);
      blk <= BW'(GAPS - 1);
    end else begin
      phase <= next_phase;
      nib <= next_nib;
      blk <= next_blk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nib_clk <= 1'b0;
      marker <= 1'b0;
      sample <= 1'b0;
    end else begin
      nib_clk <= run && (next_phase < 3'(`CLOCK_HIGH_TICKS));
      sample <= run && tick && (next_phase == 3'(`SAMPLE_EDGE));
      if (!run || realign) begin
        marker <= 1'b0;
      end else if (wrap) begin
        marker <= (next_nib == NW'(PER_BLK - 1)) && (next_blk == BW'(GAPS - 1));
      end
    end
  end
endmodule : gap_counter

// *** rtl/nib_consts.svh ***
// Offsets, field positions, reset values and timing counts of the nibble payload link
`ifndef NIB_CONSTS_SVH
`define NIB_CONSTS_SVH
`define MODE_REG_OFFSET 12'h000
`define STATUS_REG_OFFSET 12'h004
`define CAPTURE_REG_OFFSET 12'h008
`define MODE_REG_RESET 8'h00
`define LOOPBACK_BIT 7
`define TSEL_MSB 1
`define TSEL_LSB 0
`define TSEL_LOOP 2'b00
`define TSEL_SLAVE 2'b01
`define NIBBLE_BITS 4
`define PAYLOAD_BITS 4704
`define NIBBLES_PER_FRAME 1176
`define LONG_GAPS_PER_FRAME 14
`define NORMAL_GAP_TICKS 4
`define LONG_GAP_TICKS 5
`define SAMPLE_EDGE 3
`define CLOCK_HIGH_TICKS 2
`endif

// *** rtl/nib_link_if.sv ***
// Pins between the framer transmit input and the terminal equipment
`timescale 1ns/1ps
interface nib_link_if;
  logic nibble_tx_clock;
  logic [3:0] tx_nibble_in;
  logic nibble_frame_marker;
  logic frame_ref_in;
  logic overhead_indicator;
  modport device (
    output nibble_tx_clock, nibble_frame_marker, overhead_indicator,
    input tx_nibble_in, frame_ref_in
  );
  modport terminal (
    input nibble_tx_clock, nibble_frame_marker, overhead_indicator,
    output tx_nibble_in, frame_ref_in
  );
endinterface : nib_link_if

// *** rtl/nib_pkg.sv ***
// Types used by the framer end of the nibble payload link
package nib_pkg;
  typedef enum logic [2:0] {
    MODE_SER_LOOP,
    MODE_SER_SLAVE,
    MODE_SER_MASTER,
    MODE_NIB_LOOP,
    MODE_NIB_SLAVE,
    MODE_NIB_MASTER
  } mode_t;
endpackage : nib_pkg

// *** rtl/nibble_te_end.sv ***
// Terminal equipment end: launches payload nibbles on the framer's nibble clock
`timescale 1ns/1ps
`include "nib_consts.svh"
module nibble_te_end #(
  parameter int NIBBLES = `NIBBLES_PER_FRAME
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  nib_link_if.terminal link, // Framer pins
  input wire logic enable, // Drive the link
  input wire logic drive_frame_ref, // 1: terminal is frame master
  input wire logic [3:0] user_nibble, // Next payload nibble
  output logic user_take, // Pulse: user_nibble consumed
  output logic user_first // Consumed nibble opens a frame
);
  if (NIBBLES < 2) begin : g_check
    $error("nibble_te_end: NIBBLES too small");
  end

  localparam int IW = $clog2(NIBBLES);
  logic clk_prev;
  logic first_pending;
  logic [IW-1:0] idx;
  logic [3:0] data_q;
  logic ref_q;
  logic rise;

  assign rise = enable && link.nibble_tx_clock && !clk_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev <= 1'b0;
      first_pending <= 1'b0;
      idx <= '0;
      data_q <= 4'h0;
      ref_q <= 1'b0;
      user_take <= 1'b0;
      user_first <= 1'b0;
    end else begin
      clk_prev <= link.nibble_tx_clock;
      user_take <= rise;
      if (!enable) begin
        first_pending <= 1'b0;
        idx <= '0;
        ref_q <= 1'b0;
      end else if (rise) begin
        data_q <= user_nibble;
        if (drive_frame_ref) begin
          user_first <= (idx == '0);
          ref_q <= (idx == '0);
          idx <= (idx == IW'(NIBBLES - 1)) ? '0 : idx + IW'(1);
        end else begin
          // Marker up at this rise means the nibble now going out is the last
          user_first <= first_pending;
          first_pending <= link.nibble_frame_marker;
          ref_q <= 1'b0;
        end
      end
    end
  end

  assign link.tx_nibble_in = data_q;
  assign link.frame_ref_in = ref_q;
endmodule : nibble_te_end

// *** rtl/nibble_tx_device.sv ***
// Framer transmit payload input in the nibble modes, with its APB register file
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "nib_consts.svh"

// Summary of operation
// - Loop mode times from recovered line clock
// - Loop mode drives line clock divided by four
// - Nibbles captured per own nibble clock pulse
// - Marker high one nibble period, last nibble
// - Sample bus on third reference edge after pulse
// - 1176 nibble pulses between marker rises
// - Normal spacing four reference periods per pulse
// - Fourteen five-period gaps in each frame
// - Terminal launches nibble on nibble clock rise
// - After marker, terminal sends next frame's first
// - Overhead indicator held low, overhead internal
// - Strap high and select 00 picks loop
// - No local loopback in loop-timed mode
// - Slave mode divides local clock by four
// - Slave mode: frame reference rise starts a new frame
// - Terminal pulses frame reference with first nibble
// - Strap low: 01 serial slave, 1x master
module nibble_tx_device #(
  parameter int NIBBLES = `NIBBLES_PER_FRAME,
  parameter int GAPS = `LONG_GAPS_PER_FRAME
) (
  input wire logic pclk, // System clock, 20 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic recovered_line_clock, // Receive line clock pin
  input wire logic local_tx_clock, // Transmit input clock pin
  input wire logic nibble_mode_strap, // Nibble mode strap pin
  nib_link_if.device link, // Terminal equipment pins
  output logic [3:0] payload_nibble, // Last captured nibble
  output logic payload_valid, // Pulse: new nibble captured
  output logic payload_last, // Captured nibble closes a frame
  output logic local_loopback_en // Local loopback in force
);
  // Shrunk frames are allowed for fast runs; the default geometry must still add up
  if (`NIBBLES_PER_FRAME * `NIBBLE_BITS != `PAYLOAD_BITS || GAPS < 2
      || NIBBLES % GAPS != 0) begin : g_check
    $error("nibble_tx_device: unsupported frame geometry");
  end

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [1:0] ref_prev;
  logic [7:0] mode_reg;
  logic [31:0] rd_q;
  logic [15:0] frame_count;
  logic frame_ref_prev;
  logic marker_prev;
  nib_pkg::mode_t mode;
  logic run;
  logic ref_tick;
  logic realign;
  logic nib_clk;
  logic marker;
  logic sample;
  logic wr_en;
  logic setup;

  function automatic nib_pkg::mode_t decode_mode(input logic strap, input logic [1:0] tsel);
    nib_pkg::mode_t m;
    m = nib_pkg::MODE_SER_LOOP;
    if (strap) begin
      case (tsel)
        `TSEL_LOOP: m = nib_pkg::MODE_NIB_LOOP;
        `TSEL_SLAVE: m = nib_pkg::MODE_NIB_SLAVE;
        default: m = nib_pkg::MODE_NIB_MASTER;
      endcase
    end else begin
      case (tsel)
        `TSEL_LOOP: m = nib_pkg::MODE_SER_LOOP;
        `TSEL_SLAVE: m = nib_pkg::MODE_SER_SLAVE;
        default: m = nib_pkg::MODE_SER_MASTER;
      endcase
    end
    return m;
  endfunction : decode_mode

  function automatic logic is_mapped(input logic [11:0] a);
    return a == `MODE_REG_OFFSET || a == `STATUS_REG_OFFSET || a == `CAPTURE_REG_OFFSET;
  endfunction : is_mapped

  // Pins from outside pass two flops; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {nibble_mode_strap, local_tx_clock, recovered_line_clock};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev <= 2'h0;
    end else begin
      ref_prev <= sync2[1:0];
    end
  end

  assign mode = decode_mode(sync2[2], mode_reg[`TSEL_MSB:`TSEL_LSB]);
  // Serial modes and the free-running nibble master are outside this block: link idles
  assign run = (mode == nib_pkg::MODE_NIB_LOOP) || (mode == nib_pkg::MODE_NIB_SLAVE);
  assign ref_tick = (mode == nib_pkg::MODE_NIB_LOOP) ? (sync2[0] && !ref_prev[0])
                                                     : (sync2[1] && !ref_prev[1]);

  // Frame reference comes from terminal logic on this clock, so no synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_ref_prev <= 1'b0;
    end else begin
      frame_ref_prev <= link.frame_ref_in;
    end
  end
  assign realign = (mode == nib_pkg::MODE_NIB_SLAVE) && link.frame_ref_in && !frame_ref_prev;

  gap_counter #(
    .NIBBLES(NIBBLES),
    .GAPS(GAPS),
    .NORMAL_GAP(`NORMAL_GAP_TICKS),
    .LONG_GAP(`LONG_GAP_TICKS)
  ) u_gap (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .tick(ref_tick),
    .realign(realign),
    .nib_clk(nib_clk),
    .marker(marker),
    .sample(sample)
  );

  assign link.nibble_tx_clock = nib_clk;
  assign link.nibble_frame_marker = marker;
  assign link.overhead_indicator = 1'b0;

  // The terminal launches on the clock rise; the bus is settled by the third edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      payload_nibble <= 4'h0;
      payload_valid <= 1'b0;
      payload_last <= 1'b0;
    end else begin
      payload_valid <= sample;
      if (sample) begin
        payload_nibble <= link.tx_nibble_in;
        payload_last <= marker;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      marker_prev <= 1'b0;
      frame_count <= 16'h0000;
    end else begin
      marker_prev <= marker;
      if (marker && !marker_prev) begin
        frame_count <= frame_count + 16'h0001;
      end
    end
  end

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && (paddr == `MODE_REG_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);

  // A write asking for loopback together with loop timing leaves loopback off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `MODE_REG_RESET;
    end else if (wr_en) begin
      mode_reg <= pwdata[7:0];
      mode_reg[`LOOPBACK_BIT] <= pwdata[`LOOPBACK_BIT]
        && (pwdata[`TSEL_MSB:`TSEL_LSB] != `TSEL_LOOP);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_loopback_en <= 1'b0;
    end else begin
      local_loopback_en <= mode_reg[`LOOPBACK_BIT] && (mode != nib_pkg::MODE_NIB_LOOP)
        && (mode != nib_pkg::MODE_SER_LOOP);
    end
  end

  // Read data is latched in the setup cycle so the access cycle needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr)
        `MODE_REG_OFFSET: rd_q <= {24'h000000, mode_reg};
        `STATUS_REG_OFFSET: rd_q <= {frame_count, 10'h000, run, sync2[2],
                                     local_loopback_en, 3'(mode)};
        `CAPTURE_REG_OFFSET: rd_q <= {27'h0000000, payload_last, payload_nibble};
        default: rd_q <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = rd_q;
endmodule : nibble_tx_device

// *** testbench/nib_link_props.sv ***
// Assertions on the nibble link between the framer and the terminal equipment
`timescale 1ns/1ps
module nib_link_props #(
  parameter int NIBBLES = 1176,
  parameter int GAPS = 14
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic nibble_tx_clock, // Gapped nibble clock
  input wire logic [3:0] tx_nibble_in, // Payload nibble
  input wire logic nibble_frame_marker, // Last nibble marker
  input wire logic frame_ref_in, // Frame reference
  input wire logic overhead_indicator // Overhead indicator
);
  logic clk_q, ref_q, fvalid, gvalid;
  logic [7:0] gap;
  logic [15:0] pcnt, lcnt;
  wire rise = nibble_tx_clock & ~clk_q;
  wire mrise = rise & nibble_frame_marker;
  wire rrise = frame_ref_in & ~ref_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      clk_q <= nibble_tx_clock;
      ref_q <= frame_ref_in;
    end
  end
  // Spacing in pclk; saturates so an idle link never looks like a short gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= 8'hff;
    else if (rise) gap <= 8'h01;
    else if (gap != 8'hff) gap <= gap + 8'h01;
  end
  // A realign restarts the count; the long gap count is only trusted between markers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt <= 16'h0;
      lcnt <= 16'h0;
      fvalid <= 1'b0;
      gvalid <= 1'b0;
    end else if (rrise) begin
      // The realigned nibble 0 is the second pulse counted from the last marker
      pcnt <= 16'h2;
      fvalid <= 1'b1;
      gvalid <= 1'b0;
    end else if (rise && gap > 8'h28) begin
      fvalid <= 1'b0;
      gvalid <= 1'b0;
    end else if (mrise) begin
      pcnt <= 16'h1;
      lcnt <= 16'h0;
      fvalid <= 1'b1;
      gvalid <= 1'b1;
    end else if (rise) begin
      pcnt <= pcnt + 16'h1;
      lcnt <= lcnt + {15'h0, gap == 8'h28};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence hi8;
    nibble_tx_clock[*8];
  endsequence
  ohi_low_a: assert property (overhead_indicator == 1'b0)
    else $error("overhead indicator high");
  marker_edge_a: assert property ($rose(nibble_frame_marker) |-> $rose(nibble_tx_clock))
    else $error("marker rose away from a nibble clock rise");
  marker_hold_a: assert property ($rose(nibble_frame_marker) |-> (nibble_frame_marker || frame_ref_in)[*8])
    else $error("marker too short");
  clk_high_a: assert property ($rose(nibble_tx_clock) |-> hi8 ##8 nibble_tx_clock ##1 !nibble_tx_clock)
    else $error("nibble clock high time wrong");
  nib_launch_a: assert property ($changed(tx_nibble_in) |-> nibble_tx_clock)
    else $error("nibble changed while clock low");
  clk_space_a: assert property (rise && gap <= 8'h28 |-> gap == 8'h20 || gap == 8'h28)
    else $error("nibble clock spacing wrong");
  frame_len_a: assert property (mrise && fvalid |-> pcnt == 16'(NIBBLES))
    else $error("pulse count per frame wrong");
  long_gaps_a: assert property (mrise && gvalid |-> lcnt == 16'(GAPS))
    else $error("long gap count per frame wrong");
endmodule : nib_link_props

// *** testbench/tx_nibble_payload_input_test.sv ***
// Self-checking bench joining the framer and terminal ends of the nibble link
`timescale 1ns/1ps
module tx_nibble_payload_input_test;
  localparam int NIB = 28;
  localparam int GAP = 2;
  typedef struct packed {logic [3:0] nib; logic last; logic v;} note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lb, strap, te_en, te_ref;
  logic line_clk, local_clk, valid, last, take, first, er, al, tk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] unib, pnib;
  logic [2:0] ph;
  int fails, compares, seed, pos, nfirst, i;
  note_t q[$];
  note_t e;
  nib_link_if link();
  nibble_tx_device #(.NIBBLES(NIB), .GAPS(GAP)) i_nibble_tx_device (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .recovered_line_clock(line_clk), .local_tx_clock(local_clk), .nibble_mode_strap(strap),
    .link(link), .payload_nibble(pnib), .payload_valid(valid), .payload_last(last),
    .local_loopback_en(lb));
  nibble_te_end #(.NIBBLES(NIB)) i_nibble_te_end (.pclk(pclk), .presetn(presetn), .link(link),
    .enable(te_en), .drive_frame_ref(te_ref), .user_nibble(unib), .user_take(take),
    .user_first(first));
  nib_link_props #(.NIBBLES(NIB), .GAPS(GAP)) i_nib_link_props (.pclk(pclk),
    .presetn(presetn), .nibble_tx_clock(link.nibble_tx_clock),
    .tx_nibble_in(link.tx_nibble_in), .nibble_frame_marker(link.nibble_frame_marker),
    .frame_ref_in(link.frame_ref_in), .overhead_indicator(link.overhead_indicator));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Both references run at pclk/8, a quarter period apart
  always @(posedge pclk) begin
    ph <= ph + 3'h1;
    line_clk <= ph[2];
    local_clk <= (ph >= 3'h2 && ph <= 3'h5);
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic summarize();
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      summarize();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  // Runs until three frame starts, then parks the link while the clock is low
  task automatic run(input logic [31:0] m, input int d);
    int n;
    q.delete();
    nfirst = 0;
    al = 1'b0;
    tk = 1'b0;
    apb(1'b1, 12'h000, m);
    // A late terminal start makes its frame reference realign a running link
    repeat (d) @(posedge pclk);
    te_en <= 1'b1;
    for (n = 0; n < 5000 && (nfirst < 3 || link.nibble_tx_clock === 1'b1); n++) @(posedge pclk);
    if (n == 5000) begin
      fails++;
      summarize();
    end else begin
      apb(1'b0, 12'h004, 32'h0);
      chk("mode code", 32'd3 + m, {29'h0, rd[2:0]});
      chk("running", 1, rd[5]);
      apb(1'b1, 12'h000, 32'h3);
      repeat (100) @(posedge pclk);
    end
  endtask : run
  // Note what the terminal hands over; first-of-frame follows the marker
  always @(posedge pclk) begin
    if (take === 1'b1) begin
      tk = 1'b1;
      if (al) chk("first", pos == NIB, first);
      if (first === 1'b1) begin
        pos = 0;
        al = 1'b1;
        nfirst++;
      end
      q.push_back('{unib, al && pos == NIB - 1, al});
      pos++;
      unib <= 4'($random(seed));
    end
  end
  always @(posedge pclk) begin
    // Samples taken before the terminal's first hand-over carry no note
    if (valid === 1'b1 && tk === 1'b1) begin
      if (q.size() == 0) chk("queue", 1, 0);
      else begin
        e = q.pop_front();
        chk("nibble", e.nib, pnib);
        if (e.v) chk("last", e.last, last);
      end
    end
  end
  initial begin
    {psel, penable, pwrite, strap, te_en, te_ref, al, tk, presetn} = '0;
    {paddr, pwdata, unib, ph, line_clk, local_clk} = '0;
    seed = 71492;
    {fails, compares, pos, nfirst} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("mode", 32'h0, rd);
    for (i = 0; i < 8; i++) begin
      // Running nibble codes are read back inside run, where the link stops cleanly
      if (i[2] && !i[1]) continue;
      strap <= i[2];
      apb(1'b1, 12'h000, {30'h0, i[1:0]});
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      chk("mode code", (i[1] ? 2 : i[0]) + 3 * i[2], {29'h0, rd[2:0]});
    end
    strap <= 1'b0;
    apb(1'b1, 12'h000, 32'h81);
    apb(1'b0, 12'h000, 32'h0);
    chk("mode", 32'h81, rd);
    chk("loopback", 1, lb);
    apb(1'b1, 12'h000, 32'h80);
    apb(1'b0, 12'h000, 32'h0);
    chk("mode", 32'h0, rd);
    chk("loopback", 0, lb);
    apb(1'b1, 12'h00c, 32'h1);
    chk("slverr", 1, er);
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", 1, er);
    chk("rdata", 0, rd);
    te_en <= 1'b1;
    strap <= 1'b1;
    run(32'h0, 0);
    te_en <= 1'b0;
    te_ref <= 1'b1;
    run(32'h1, 100);
    summarize();
  end
endmodule : tx_nibble_payload_input_test
